// ### rtl/pwt_pkg.sv
// pwt_pkg: register map, field positions, reset values and timing constants
// for the pwm timing unit; used by rtl/pwt_timing_unit.sv only via pwt_pkg::
package pwt_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    // carrier counts are 16-bit integers; duty, phase and scale are 16-bit fractions with UNIT_ONE = 1.0
    localparam logic [15:0] CARRIER_MAX = 16'hFFFF;
    localparam logic [15:0] UNIT_ONE = 16'h8000;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] PERIOD_OFF = 8'h04;
    localparam logic [7:0] DUTY1_OFF = 8'h08;
    localparam logic [7:0] DUTY2_OFF = 8'h0C;
    localparam logic [7:0] FSCALE_OFF = 8'h10;
    localparam logic [7:0] PHASE_OFF = 8'h14;
    localparam logic [7:0] BLANK_OFF = 8'h18;
    localparam logic [7:0] TRIG_OFF = 8'h1C;
    localparam logic [7:0] STATUS_OFF = 8'h20;
    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SYMM = 1;
    localparam int CTRL_MASTER = 2;
    localparam int CTRL_FVAR = 3;
    localparam int CTRL_PHEN = 4;
    localparam int CTRL_COMPL = 5;
    localparam int CTRL_POL = 6;
    localparam int CTRL_IDLE = 7;
    localparam int CTRL_FLT_LO = 8;
    localparam int CTRL_BURST = 10;
    localparam int CTRL_EN1 = 11;
    localparam int CTRL_EN2 = 12;
    localparam int CTRL_TUE = 13;
    localparam int CTRL_W = 14;
    // trigger field positions
    localparam int TRIG_ADC_EN = 0;
    localparam int TRIG_MID = 1;
    localparam int TRIG_TASK_EN = 2;
    localparam int TRIG_ON_OVF = 3;
    localparam int TRIG_REP_LO = 8;
    localparam int TRIG_W = 16;
    // reset values
    localparam logic [13:0] CTRL_RST = 14'h1800;
    localparam logic [15:0] PERIOD_RST = 16'h03E8;
    localparam logic [15:0] FSCALE_RST = 16'h8000;
    localparam logic [15:0] BLANK_RST = 16'h0014;
    localparam logic [15:0] TRIG_RST = 16'h0100;
    // fault state encodings
    typedef enum logic [1:0] {
        FLT_INACTIVE = 2'b00,
        FLT_ACTIVE = 2'b01,
        FLT_HIGHZ = 2'b10
    } pwt_fault_type;
    // ahb constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// ### rtl/pwt_timing_unit.sv
// pwt_timing_unit: pwm timing unit with carrier, two outputs, triggers
// assumes one 20 MHz clock, AHB-Lite single-slave bus, synchronous inputs
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

// What this block does
// - carrier is sawtooth or symmetrical triangle
// - master sync uses master period, not own
// - frequency scale only when self synchronised
// - phase offset only when master synchronised
// - enable input low forces idle level
// - independent pair or complementary pair mode
// - two duties, two enables, shared carrier
// - polarity sets active level for all states
// - blanking delay between complementary edges
// - idle on enable, interlock or burst
// - sawtooth midpoint adc trigger tracks duty
// - sawtooth period adc trigger; none unit e
// - sawtooth task trigger at overflow
// - repetition counter gates trigger forwarding
// - symmetrical: underflow or overflow selected
// - underflow at minimum, overflow at maximum
// - burst follows master only when enabled
// - trip enters configured fault level
// - one fault state releases to high impedance
// - output active while duty exceeds carrier
// - master sync high restarts counter at zero, or at phase offset when enabled
// - scaled frequency is nominal times scale
module pwt_timing_unit
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic master_sync,
    input wire logic [15:0] master_period,
    input wire logic master_burst_idle,
    input wire logic interlock_en,
    input wire logic protection_trip,
    input wire logic enable1_in,
    input wire logic enable2_in,
    output logic pwm1_out,
    output logic pwm1_oe,
    output logic pwm2_out,
    output logic pwm2_oe,
    output logic adc_trigger,
    output logic task_trigger,
    output logic overflow_event,
    output logic underflow_event
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // fraction of the period: value * period / one, with saturation
    function automatic logic [15:0] frac_of(input logic [15:0] value,
                                            input logic [15:0] period);
        logic [31:0] prod;
        logic [15:0] v;
        v = (value > pwt_pkg::UNIT_ONE) ? pwt_pkg::UNIT_ONE : value;
        prod = v * period;
        frac_of = prod[30:15];
    endfunction

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    logic [13:0] ctrl, next_ctrl;
    logic [15:0] period, next_period;
    logic [15:0] duty1, next_duty1;
    logic [15:0] duty2, next_duty2;
    logic [15:0] fscale, next_fscale;
    logic [15:0] phase, next_phase;
    logic [15:0] blank, next_blank;
    logic [15:0] trig, next_trig;
    logic [31:0] next_hrdata;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic fault_latched, next_fault_latched;
    logic [15:0] count, next_count;
    logic down, next_down;
    logic [7:0] rep_cnt, next_rep_cnt;
    logic [15:0] eff_period;
    logic [15:0] cmp1, cmp2;
    logic ovf, unf;
    logic sync_restart;

    always_comb
    begin
        next_ctrl = ctrl;
        next_period = period;
        next_duty1 = duty1;
        next_duty2 = duty2;
        next_fscale = fscale;
        next_phase = phase;
        next_blank = blank;
        next_trig = trig;
        next_hrdata = hrdata;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        if (wr_pend)
        begin
            if (wr_addr == pwt_pkg::CTRL_OFF)
                next_ctrl = hwdata[13:0];
            else if (wr_addr == pwt_pkg::PERIOD_OFF)
                next_period = hwdata[15:0];
            else if (wr_addr == pwt_pkg::DUTY1_OFF)
                next_duty1 = hwdata[15:0];
            else if (wr_addr == pwt_pkg::DUTY2_OFF)
                next_duty2 = hwdata[15:0];
            else if (wr_addr == pwt_pkg::FSCALE_OFF)
                next_fscale = hwdata[15:0];
            else if (wr_addr == pwt_pkg::PHASE_OFF)
                next_phase = hwdata[15:0];
            else if (wr_addr == pwt_pkg::BLANK_OFF)
                next_blank = hwdata[15:0];
            else if (wr_addr == pwt_pkg::TRIG_OFF)
                next_trig = hwdata[15:0];
        end
        if (hsel && hready && htrans == pwt_pkg::HTRANS_NONSEQ)
        begin
            next_wr_pend = hwrite;
            next_wr_addr = haddr[7:0];
            next_hrdata = 32'h0000_0000;
            if (!hwrite)
            begin
                if (haddr[7:0] == pwt_pkg::CTRL_OFF)
                    next_hrdata = {18'h00000, ctrl};
                else if (haddr[7:0] == pwt_pkg::PERIOD_OFF)
                    next_hrdata = {16'h0000, period};
                else if (haddr[7:0] == pwt_pkg::DUTY1_OFF)
                    next_hrdata = {16'h0000, duty1};
                else if (haddr[7:0] == pwt_pkg::DUTY2_OFF)
                    next_hrdata = {16'h0000, duty2};
                else if (haddr[7:0] == pwt_pkg::FSCALE_OFF)
                    next_hrdata = {16'h0000, fscale};
                else if (haddr[7:0] == pwt_pkg::PHASE_OFF)
                    next_hrdata = {16'h0000, phase};
                else if (haddr[7:0] == pwt_pkg::BLANK_OFF)
                    next_hrdata = {16'h0000, blank};
                else if (haddr[7:0] == pwt_pkg::TRIG_OFF)
                    next_hrdata = {16'h0000, trig};
                else if (haddr[7:0] == pwt_pkg::STATUS_OFF)
                    next_hrdata = {12'h000, fault_latched, down,
                                   rep_cnt[1:0], count};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= pwt_pkg::CTRL_RST;
            period <= pwt_pkg::PERIOD_RST;
            duty1 <= 16'h0000;
            duty2 <= 16'h0000;
            fscale <= pwt_pkg::FSCALE_RST;
            phase <= 16'h0000;
            blank <= pwt_pkg::BLANK_RST;
            trig <= pwt_pkg::TRIG_RST;
            hrdata <= 32'h0000_0000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            ctrl <= next_ctrl;
            period <= next_period;
            duty1 <= next_duty1;
            duty2 <= next_duty2;
            fscale <= next_fscale;
            phase <= next_phase;
            blank <= next_blank;
            trig <= next_trig;
            hrdata <= next_hrdata;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // carrier counter
    // ------------------------------------------------------------
    logic [31:0] scaled;
    always_comb
    begin
        scaled = 32'h0000_0000;
        if (ctrl[pwt_pkg::CTRL_MASTER])
            eff_period = master_period;
        else if (ctrl[pwt_pkg::CTRL_FVAR] && fscale != 16'h0000)
        begin
            // higher frequency is a shorter period: period / scale
            scaled = ({16'h0000, period} << 15) / {16'h0000, fscale};
            eff_period = (scaled[31:16] != 16'h0000) ? pwt_pkg::CARRIER_MAX
                       : scaled[15:0];
        end
        else
            eff_period = period;
        if (eff_period == 16'h0000)
            eff_period = 16'h0001;
    end

    // master sync restarts at zero, or at the phase offset position when enabled
    assign sync_restart = ctrl[pwt_pkg::CTRL_MASTER] && master_sync;
    assign ovf = ctrl[pwt_pkg::CTRL_RUN] && count == eff_period
               && (!ctrl[pwt_pkg::CTRL_SYMM] || !down);
    assign unf = ctrl[pwt_pkg::CTRL_RUN] && ctrl[pwt_pkg::CTRL_SYMM]
               && down && count == 16'h0000;

    always_comb
    begin
        next_count = count + 16'h0001;
        next_down = down;
        if (!ctrl[pwt_pkg::CTRL_RUN])
        begin
            next_count = 16'h0000;
            next_down = 1'b0;
        end
        else if (sync_restart)
        begin
            next_count = ctrl[pwt_pkg::CTRL_PHEN]
                       ? frac_of(phase, eff_period) : 16'h0000;
            next_down = 1'b0;
        end
        else if (!ctrl[pwt_pkg::CTRL_SYMM] && count >= eff_period)
            next_count = 16'h0000;
        else if (ctrl[pwt_pkg::CTRL_SYMM])
        begin
            next_down = down ? count != 16'h0000 : count >= eff_period;
            if (next_down)
                next_count = count - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // compare, blanking and output stage
    // ------------------------------------------------------------
    // compare values saturated to full scale
    assign cmp1 = frac_of(duty1, eff_period);
    assign cmp2 = frac_of(duty2, eff_period);

    logic raw1, raw2;
    logic dt1, dt2, next_dt1, next_dt2;
    logic [15:0] dcnt, next_dcnt;
    logic ref_q, next_ref_q;
    assign raw1 = cmp1 > count || duty1 >= pwt_pkg::UNIT_ONE;
    assign raw2 = ctrl[pwt_pkg::CTRL_COMPL] ? !raw1
                : (cmp2 > count || duty2 >= pwt_pkg::UNIT_ONE);

    // in complementary mode, on any reference edge both sides go inactive for blank cycles
    always_comb
    begin
        next_ref_q = raw1;
        next_dcnt = 16'h0000;
        next_dt1 = raw1;
        next_dt2 = raw2;
        if (ctrl[pwt_pkg::CTRL_COMPL] && raw1 != ref_q)
            next_dcnt = blank;
        else if (ctrl[pwt_pkg::CTRL_COMPL] && dcnt != 16'h0000)
            next_dcnt = dcnt - 16'h0001;
        if (ctrl[pwt_pkg::CTRL_COMPL] && (raw1 != ref_q || dcnt > 16'h0001))
        begin
            next_dt1 = 1'b0;
            next_dt2 = 1'b0;
        end
    end

    always_comb
    begin
        next_fault_latched = fault_latched;
        if (protection_trip)
            next_fault_latched = 1'b1;
        else if (!interlock_en)
            next_fault_latched = 1'b0;
    end

    logic idle1, idle2, pol, idle_act;
    logic [1:0] flt;
    logic next_p1, next_p2, next_oe1, next_oe2;
    assign pol = ctrl[pwt_pkg::CTRL_POL];
    assign idle_act = ctrl[pwt_pkg::CTRL_IDLE];
    assign flt = ctrl[pwt_pkg::CTRL_FLT_LO +: 2];
    // burst control only honoured under master sync
    assign idle1 = !enable1_in || !ctrl[pwt_pkg::CTRL_EN1] || !interlock_en
        || (ctrl[pwt_pkg::CTRL_BURST] && ctrl[pwt_pkg::CTRL_MASTER]
            && master_burst_idle);
    assign idle2 = (ctrl[pwt_pkg::CTRL_COMPL] ? !enable1_in : !enable2_in)
        || !ctrl[pwt_pkg::CTRL_EN2] || !interlock_en
        || (ctrl[pwt_pkg::CTRL_BURST] && ctrl[pwt_pkg::CTRL_MASTER]
            && master_burst_idle);

    always_comb
    begin
        // levels are active/inactive mapped through polarity
        next_p1 = (idle1 ? idle_act : dt1) ? pol : !pol;
        next_p2 = (idle2 ? idle_act : dt2) ? pol : !pol;
        next_oe1 = 1'b1;
        next_oe2 = 1'b1;
        if (fault_latched || protection_trip)
        begin
            next_p1 = (flt == pwt_pkg::FLT_ACTIVE) ? pol : !pol;
            next_p2 = next_p1;
            next_oe1 = flt != pwt_pkg::FLT_HIGHZ;
            next_oe2 = next_oe1;
        end
    end

    // ------------------------------------------------------------
    // trigger generation
    // ------------------------------------------------------------
    logic ev, mid_ev, next_adc, next_task;
    logic [7:0] rep_set;
    assign rep_set = trig[pwt_pkg::TRIG_REP_LO +: 8];
    // midpoint of on-time [0, cmp1) in sawtooth
    assign mid_ev = ctrl[pwt_pkg::CTRL_RUN] && cmp1 != 16'h0000
                  && count == {1'b0, cmp1[15:1]};
    always_comb
    begin
        if (ctrl[pwt_pkg::CTRL_SYMM])
            ev = trig[pwt_pkg::TRIG_ON_OVF] ? ovf : unf;
        else
            ev = ovf;
        next_rep_cnt = rep_cnt;
        next_adc = 1'b0;
        next_task = 1'b0;
        if (ev)
        begin
            if (rep_cnt + 8'h01 >= rep_set)
            begin
                next_rep_cnt = 8'h00;
                next_task = trig[pwt_pkg::TRIG_TASK_EN];
                next_adc = trig[pwt_pkg::TRIG_ADC_EN]
                    && (ctrl[pwt_pkg::CTRL_SYMM] || (!trig[pwt_pkg::TRIG_MID]
                        && !ctrl[pwt_pkg::CTRL_TUE]));
            end
            else
                next_rep_cnt = rep_cnt + 8'h01;
        end
        if (mid_ev && !ctrl[pwt_pkg::CTRL_SYMM] && trig[pwt_pkg::TRIG_MID]
            && trig[pwt_pkg::TRIG_ADC_EN] && rep_cnt == 8'h00)
            next_adc = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 16'h0000;
            down <= 1'b0;
            ref_q <= 1'b0;
            dcnt <= 16'h0000;
            dt1 <= 1'b0;
            dt2 <= 1'b0;
            fault_latched <= 1'b0;
            pwm1_out <= 1'b0;
            pwm2_out <= 1'b0;
            pwm1_oe <= 1'b0;
            pwm2_oe <= 1'b0;
            rep_cnt <= 8'h00;
            adc_trigger <= 1'b0;
            task_trigger <= 1'b0;
            overflow_event <= 1'b0;
            underflow_event <= 1'b0;
        end
        else
        begin
            count <= next_count;
            down <= next_down;
            ref_q <= next_ref_q;
            dcnt <= next_dcnt;
            dt1 <= next_dt1;
            dt2 <= next_dt2;
            fault_latched <= next_fault_latched;
            pwm1_out <= next_p1;
            pwm2_out <= next_p2;
            pwm1_oe <= next_oe1;
            pwm2_oe <= next_oe2;
            rep_cnt <= next_rep_cnt;
            adc_trigger <= next_adc;
            task_trigger <= next_task;
            overflow_event <= ovf;
            underflow_event <= unf;
        end
    end

endmodule

// ### test/pwt_timing_unit_asserts.sv
// checker for the pwm timing unit top ports
// assumes one clock domain with async active-low reset
`timescale 1ns/1ps

module pwt_timing_unit_asserts
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic interlock_en,
    input wire logic protection_trip,
    input wire logic pwm1_out,
    input wire logic pwm1_oe,
    input wire logic pwm2_out,
    input wire logic pwm2_oe,
    input wire logic task_trigger,
    input wire logic overflow_event,
    input wire logic underflow_event
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ----
    // protection and idle sequences
    // ----
    sequence s_tripped;
        protection_trip && interlock_en ##1 interlock_en [*3];
    endsequence
    sequence s_idle_run;
        (!interlock_en && !protection_trip) [*4];
    endsequence

    a_bus_okay: assert property
        (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_ovf_pulse: assert property
        (overflow_event |=> !overflow_event)
        else $error("overflow event longer than one cycle");
    a_event_excl: assert property
        (!(overflow_event && underflow_event))
        else $error("overflow and underflow together");
    a_task_pulse: assert property
        (task_trigger |=> !task_trigger)
        else $error("task trigger longer than one cycle");
    a_task_cause: assert property
        (task_trigger |-> overflow_event || underflow_event
            || $past(overflow_event) || $past(underflow_event))
        else $error("task trigger without carrier event");
    a_fault_hold: assert property
        (s_tripped |=> $stable({pwm1_out, pwm1_oe, pwm2_out, pwm2_oe}))
        else $error("outputs moved while fault latched");
    a_idle_hold: assert property
        (s_idle_run |=> $stable({pwm1_out, pwm2_out}) && pwm1_oe && pwm2_oe)
        else $error("outputs not held idle");
    a_hiz_pair: assert property
        (pwm1_oe == pwm2_oe)
        else $error("output enables differ");
endmodule

bind pwt_timing_unit pwt_timing_unit_asserts chk_u (.*);

// ### test/pwt_gate_drv.sv
// gate driver model facing the pwm outputs
// assumes pulled-down gate inputs when pins are released
`timescale 1ns/1ps

module pwt_gate_drv
(
    input wire logic pwm1_out,
    input wire logic pwm1_oe,
    input wire logic pwm2_out,
    input wire logic pwm2_oe,
    output logic gate1,
    output logic gate2
);
    // released pins fall to the pull-down level
    assign gate1 = pwm1_oe ? pwm1_out : 1'b0;
    assign gate2 = pwm2_oe ? pwm2_out : 1'b0;
endmodule

// ### test/test_pwt_timing_unit.sv
// self-checking bench for the pwm timing unit
// assumes the checker bind and the gate driver model
`timescale 1ns/1ps

module test_pwt_timing_unit;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic master_sync, master_burst_idle, interlock_en, protection_trip;
    logic [15:0] master_period;
    logic enable1_in, enable2_in, pwm1_out, pwm1_oe, pwm2_out, pwm2_oe;
    logic adc_trigger, task_trigger, overflow_event, underflow_event;
    logic gate1, gate2;
    int errors, comparisons, n, h1, h2, nt, na, nu, pa;

    assign hready = hreadyout;

    pwt_timing_unit dut_u (.*);
    pwt_gate_drv drv_u (.*);

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ----
    // shared tasks
    // ----
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task rng(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("Error at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= pwt_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    // one carrier period between overflow events
    task meas;
        int k;
        k = 0;
        n = 0;
        h1 = 0;
        h2 = 0;
        nt = 0;
        na = 0;
        nu = 0;
        pa = 0;
        while (overflow_event !== 1'b1 && k < 4000)
        begin
            @(posedge hclk);
            k++;
        end
        do
        begin
            @(posedge hclk);
            n++;
            h1 += int'(pwm1_out === 1'b1);
            h2 += int'(pwm2_out === 1'b1);
            nt += int'(task_trigger === 1'b1);
            nu += int'(underflow_event === 1'b1);
            if (adc_trigger === 1'b1)
            begin
                na++;
                pa = n;
            end
        end
        while (overflow_event !== 1'b1 && n < 4000);
    endtask

    task meas2;
        meas;
        meas;
    endtask

    // ----
    // scenarios
    // ----
    task t_regs;
        logic [7:0] ad[6];
        logic [31:0] ex[6];
        ad = '{pwt_pkg::CTRL_OFF, pwt_pkg::PERIOD_OFF, pwt_pkg::FSCALE_OFF,
               pwt_pkg::BLANK_OFF, pwt_pkg::TRIG_OFF, 8'h40};
        ex = '{32'(pwt_pkg::CTRL_RST), 32'(pwt_pkg::PERIOD_RST),
               32'(pwt_pkg::FSCALE_RST), 32'(pwt_pkg::BLANK_RST),
               32'(pwt_pkg::TRIG_RST), 32'h00000000};
        wr(8'h40, 32'hFFFFFFFF);
        foreach (ad[i])
        begin
            xfer(1'b0, ad[i], 32'h00000000);
            chk(rv, ex[i]);
        end
        wr(pwt_pkg::DUTY1_OFF, 32'hFFFF4000);
        xfer(1'b0, pwt_pkg::DUTY1_OFF, 32'h00000000);
        chk(rv, 32'h00004000);
        wr(pwt_pkg::DUTY2_OFF, 32'h0000FFFF);
        $display("t_regs done");
    endtask

    task t_idle;
        logic [31:0] cf[8];
        logic [3:0] pin[8];
        cf = '{32'h00001840, 32'h000018C0, 32'h00001880, 32'h00001800,
               32'h00001840, 32'h00001C44, 32'h00001844, 32'h00001840};
        // enable2, interlock, burst idle, expected level
        pin = '{4'h4, 4'h5, 4'h4, 4'h5, 4'h8, 4'hE, 4'hF, 4'hD};
        foreach (cf[i])
        begin
            wr(pwt_pkg::CTRL_OFF, cf[i]);
            {enable2_in, interlock_en, master_burst_idle} <= pin[i][3:1];
            repeat (4) @(posedge hclk);
            chk(pwm2_out, pin[i][0]);
        end
        $display("t_idle done");
    endtask

    task t_fault;
        for (int f = 0; f < 3; f++)
        begin
            wr(pwt_pkg::CTRL_OFF, 32'h00001840 | (32'(f) << 8));
            protection_trip <= 1'b1;
            repeat (5) @(posedge hclk);
            chk({pwm1_oe, pwm2_oe}, {2{f != 2}});
            chk({gate1, gate2}, {2{f == 1}});
            interlock_en <= 1'b0;
            repeat (4) @(posedge hclk);
            chk({gate1, gate2}, {2{f == 1}});
            protection_trip <= 1'b0;
            repeat (4) @(posedge hclk);
            chk({pwm1_oe, gate1}, 2'b10);
            interlock_en <= 1'b1;
            @(posedge hclk);
        end
        $display("t_fault done");
    endtask

    task t_saw;
        int p1;
        wr(pwt_pkg::PERIOD_OFF, 32'h00000009);
        wr(pwt_pkg::TRIG_OFF, 32'h00000005);
        wr(pwt_pkg::CTRL_OFF, 32'h00001841);
        meas2;
        rng(n, 10, 10);
        rng(h1, 4, 6);
        rng(h2, n, n);
        rng(nt, 1, 1);
        rng(na, 1, 1);
        wr(pwt_pkg::TRIG_OFF, 32'h00000003);
        meas2;
        p1 = pa;
        rng(pa, 1, 7);
        wr(pwt_pkg::DUTY1_OFF, 32'h00007000);
        meas2;
        rng(pa - p1, 1, 3);
        wr(pwt_pkg::TRIG_OFF, 32'h00000005);
        wr(pwt_pkg::CTRL_OFF, 32'h00003841);
        meas2;
        rng(na, 0, 0);
        $display("t_saw done");
    endtask

    task t_symm;
        int s;
        wr(pwt_pkg::TRIG_OFF, 32'h0000020D);
        wr(pwt_pkg::CTRL_OFF, 32'h00001843);
        meas2;
        s = na;
        meas;
        rng(s + na, 1, 1);
        rng(nu, 1, 1);
        rng(n, 17, 19);
        wr(pwt_pkg::TRIG_OFF, 32'h00000005);
        meas2;
        rng(na, 1, 1);
        rng(pa, n / 2 - 2, n / 2 + 2);
        wr(pwt_pkg::TRIG_OFF, 32'h0000000D);
        meas2;
        rng(na, 1, 1);
        rng((pa + 2) % n, 0, 3);
        $display("t_symm done");
    endtask

    task t_comp;
        wr(pwt_pkg::PERIOD_OFF, 32'h00000013);
        wr(pwt_pkg::BLANK_OFF, 32'h00000004);
        wr(pwt_pkg::DUTY1_OFF, 32'h00004000);
        wr(pwt_pkg::CTRL_OFF, 32'h00001861);
        meas2;
        rng(n - h1 - h2, 8, 10);
        rng(h2, 1, n);
        wr(pwt_pkg::CTRL_OFF, 32'h000018E1);
        enable1_in <= 1'b0;
        repeat (4) @(posedge hclk);
        chk({pwm1_out, pwm2_out}, 2'b11);
        enable1_in <= 1'b1;
        $display("t_comp done");
    endtask

    task sync_gap(input int w, output int d);
        d = 0;
        do @(posedge hclk); while (overflow_event !== 1'b1);
        repeat (w) @(posedge hclk);
        master_sync <= 1'b1;
        @(posedge hclk);
        master_sync <= 1'b0;
        do
        begin
            @(posedge hclk);
            d++;
        end
        while (overflow_event !== 1'b1 && d < 4000);
    endtask

    task t_master;
        int d1, d2;
        wr(pwt_pkg::CTRL_OFF, 32'h00001845);
        meas2;
        rng(n, 12, 12);
        sync_gap(3, d1);
        sync_gap(7, d2);
        rng(d1 - d2, 0, 0);
        rng(d1, 11, 15);
        wr(pwt_pkg::PHASE_OFF, 32'h00004000);
        wr(pwt_pkg::CTRL_OFF, 32'h00001855);
        sync_gap(3, d2);
        rng(d1 - d2, 5, 6);
        wr(pwt_pkg::FSCALE_OFF, 32'h00004000);
        wr(pwt_pkg::CTRL_OFF, 32'h0000184D);
        meas2;
        rng(n, 12, 12);
        wr(pwt_pkg::CTRL_OFF, 32'h00001849);
        meas2;
        rng(n, 39, 40);
        $display("t_master done");
    endtask

    initial
    begin
        #1000000;
        errors++;
        end_sim;
    end

    initial
    begin
        errors = 0;
        comparisons = 0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {master_sync, master_burst_idle, protection_trip} = 3'h0;
        {interlock_en, enable1_in, enable2_in} = 3'h7;
        master_period = 16'h000B;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_idle;
        t_fault;
        t_saw;
        t_symm;
        t_comp;
        t_master;
        end_sim;
    end
endmodule
